// ==== dpl_leveling.sv ====
`timescale 1ns/10ps
`include "dpl_consts.svh"

module dpl_leveling
	import dpl_pkg::*;
#(
	parameter int LANES         = `DPL_LANES,
	parameter int TAP_WIDTH     = `DPL_TAP_WIDTH,
	parameter int SETTLE_CYCLES = `DPL_SETTLE_CYCLES
) (
	input  wire logic                       clock,
	input  wire logic                       reset,
	input  wire logic                       clock_enable,
	input  wire logic                       seed_load,
	input  wire logic [3:0]                 seed_lane,
	input  wire logic [1:0]                 seed_mode,
	input  wire logic [TAP_WIDTH-1:0]       seed_value,
	input  wire logic                       level_start,
	input  wire logic [1:0]                 level_mode,
	input  wire logic                       clock_output_polarity_flip,
	input  wire logic [LANES-1:0]           lane_feedback,
	output logic [LANES*TAP_WIDTH-1:0]      write_level_delay,
	output logic [LANES*TAP_WIDTH-1:0]      read_eye_delay,
	output logic [LANES*TAP_WIDTH-1:0]      gate_level_delay,
	output logic                            level_busy,
	output logic                            write_level_done,
	output logic                            read_eye_done,
	output logic                            gate_level_done,
	output logic [LANES-1:0]                lane_failed,
	output logic                            memory_clock
);

	// ==========================================================
	// Feedback synchroniser
	// ==========================================================
	// Pins run free of this clock; lanes read only the second stage
	logic [LANES-1:0] feedback_meta;
	logic [LANES-1:0] feedback_sync;
	logic [LANES-1:0] next_feedback_meta;
	logic [LANES-1:0] next_feedback_sync;

	always_comb begin
		next_feedback_meta = lane_feedback;
		next_feedback_sync = feedback_meta;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			feedback_meta <= '0;
			feedback_sync <= '0;
		end else if (clock_enable) begin
			feedback_meta <= next_feedback_meta;
			feedback_sync <= next_feedback_sync;
		end
	end

	// ==========================================================
	// Run control
	// ==========================================================
	dpl_state_t       state;
	dpl_state_t       next_state;
	logic [1:0]       run_mode;
	logic [1:0]       next_run_mode;
	logic             run_start;
	logic             next_run_start;
	logic [15:0]      settle_count;
	logic [15:0]      next_settle_count;
	logic             sample_tick;
	logic             next_sample_tick;
	logic [2:0]       done_flags;
	logic [2:0]       next_done_flags;
	logic             next_level_busy;
	logic [LANES-1:0] lane_active;
	logic [LANES-1:0] lane_fail_live;

	// Wraps at the last settle cycle; 16 bits covers any sane settle time
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

	always_comb begin
		next_state        = state;
		next_run_mode     = run_mode;
		next_run_start    = 1'b0;
		next_settle_count = settle_count;
		next_sample_tick  = 1'b0;
		next_done_flags   = done_flags;
		next_level_busy   = level_busy;
		case (state)
			DPL_ST_IDLE: begin
				// Start heard only here; a start while busy is dropped
				// Unused mode code is ignored
				if (level_start && level_mode != 2'b11) begin
					next_state        = DPL_ST_RUN;
					next_run_mode     = level_mode;
					next_run_start    = 1'b1;
					next_settle_count = 16'h0000;
					next_level_busy   = 1'b1;
					// Stale done must not survive a rerun of the same mode
					next_done_flags[level_mode] = 1'b0;
				end
			end
			DPL_ST_RUN: begin
				// Each tap step waits out the delay-line settle time before sampling
				if (settle_count == SETTLE_LAST) begin
					next_settle_count = 16'h0000;
					next_sample_tick  = 1'b1;
				end else begin
					next_settle_count = settle_count + 16'h0001;
				end
				// Lanes are not loaded yet while run_start stands
				if (!run_start && lane_active == '0) begin
					next_state = DPL_ST_FINISH;
				end
			end
			DPL_ST_FINISH: begin
				// Busy falls and done rises on one edge, so polling either is safe
				next_state      = DPL_ST_IDLE;
				next_level_busy = 1'b0;
				next_done_flags[run_mode] = 1'b1;
			end
			default: begin
				// Unused state code falls back to idle
				next_state      = DPL_ST_IDLE;
				next_level_busy = 1'b0;
			end
		endcase
	end

	// Clock enable low holds the whole sequencer where it stands
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state        <= DPL_ST_IDLE;
			run_mode     <= 2'b00;
			run_start    <= 1'b0;
			settle_count <= 16'h0000;
			sample_tick  <= 1'b0;
			done_flags   <= 3'h0;
			level_busy   <= 1'b0;
		end else if (clock_enable) begin
			state        <= next_state;
			run_mode     <= next_run_mode;
			run_start    <= next_run_start;
			settle_count <= next_settle_count;
			sample_tick  <= next_sample_tick;
			done_flags   <= next_done_flags;
			level_busy   <= next_level_busy;
		end
	end

	// ==========================================================
	// Completion flags
	// ==========================================================
	// Flags are flops; this only picks bits
	always_comb begin
		write_level_done = done_flags[DPL_MODE_WRITE];
		read_eye_done    = done_flags[DPL_MODE_EYE];
		gate_level_done  = done_flags[DPL_MODE_GATE];
	end

	// ==========================================================
	// Byte lanes
	// ==========================================================
	// One shared seed bus; the lane number picks the target
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : gen_lane
			logic lane_seed_load;
			assign lane_seed_load = seed_load && (seed_lane == 4'(g));
			dpl_lane #(
				.TAP_WIDTH (TAP_WIDTH)
			) u_lane (
				.clock             (clock),
				.reset             (reset),
				.clock_enable      (clock_enable),
				.seed_load         (lane_seed_load),
				.seed_mode         (seed_mode),
				.seed_value        (seed_value),
				.run_start         (run_start),
				.run_mode          (run_mode),
				.sample_tick       (sample_tick),
				.feedback          (feedback_sync[g]),
				.write_level_delay (write_level_delay[g*TAP_WIDTH +: TAP_WIDTH]),
				.read_eye_delay    (read_eye_delay[g*TAP_WIDTH +: TAP_WIDTH]),
				.gate_level_delay  (gate_level_delay[g*TAP_WIDTH +: TAP_WIDTH]),
				.active            (lane_active[g]),
				.failed            (lane_fail_live[g])
			);
		end
	endgenerate

	// ==========================================================
	// Lane status
	// ==========================================================
	// Fail flags are flops inside each lane, cleared at the next start
	always_comb begin
		lane_failed = lane_fail_live;
	end

	// ==========================================================
	// Memory clock, half the core rate
	// ==========================================================
	// Limitation: a flip while running jumps the clock by half a period
	logic clock_phase;
	logic next_clock_phase;
	logic next_memory_clock;

	always_comb begin
		next_clock_phase  = ~clock_phase;
		// Inverted drive adds an apparent half period to the fly-by path
		next_memory_clock = next_clock_phase ^ clock_output_polarity_flip;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			// Both low in reset; the first enabled edge drives the clock high, or low if the polarity flip is set
			clock_phase  <= 1'b0;
			memory_clock <= 1'b0;
		end else if (clock_enable) begin
			clock_phase  <= next_clock_phase;
			memory_clock <= next_memory_clock;
		end
	end

endmodule

// ==== dpl_consts.svh ====
// Overview of operation
// - Three leveling modes exist: write leveling, read-eye training, read-gate training.
// - Write leveling finds a separate data-group delay per byte lane.
// - All nine byte lanes converge in parallel within one run.
// - Per-lane, per-mode seeds are loaded first; search starts from them.
// - Seeds and results are taps, 256 taps per clock period.
// - Search only increases delay; seeds carry a 128-tap negative offset. The lanes start at the raw seed; DPL_SEED_OFFSET is never applied.
// - Polarity flip drives the memory clock inverted, a half-period shift.
// - Inversion only when the flip control is set; otherwise clock is true.
`ifndef DPL_CONSTS_SVH
`define DPL_CONSTS_SVH

`define DPL_LANES            9
`define DPL_MODES            3
`define DPL_TAPS_PER_CLOCK   256
`define DPL_TAP_WIDTH        8
`define DPL_SEED_OFFSET      128
`define DPL_TAP_MAX          8'hFF
`define DPL_SEED_RESET       8'h00
`define DPL_CLOCK_PERIOD_NS  10
`define DPL_SETTLE_NS        40
`define DPL_SETTLE_CYCLES    ((`DPL_SETTLE_NS + `DPL_CLOCK_PERIOD_NS - 1) / `DPL_CLOCK_PERIOD_NS)

`endif

// ==== dpl_pkg.sv ====
package dpl_pkg;

	typedef enum logic [1:0] {
		DPL_MODE_WRITE = 2'b00,
		DPL_MODE_EYE   = 2'b01,
		DPL_MODE_GATE  = 2'b10
	} dpl_mode_t;

	typedef enum logic [1:0] {
		DPL_ST_IDLE   = 2'b00,
		DPL_ST_RUN    = 2'b01,
		DPL_ST_FINISH = 2'b10
	} dpl_state_t;

endpackage

// ==== dpl_lane.sv ====
`timescale 1ns/10ps
`include "dpl_consts.svh"

module dpl_lane
	import dpl_pkg::*;
#(
	parameter int TAP_WIDTH = `DPL_TAP_WIDTH
) (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic                 clock_enable,
	input  wire logic                 seed_load,
	input  wire logic [1:0]           seed_mode,
	input  wire logic [TAP_WIDTH-1:0] seed_value,
	input  wire logic                 run_start,
	input  wire logic [1:0]           run_mode,
	input  wire logic                 sample_tick,
	input  wire logic                 feedback,
	output logic [TAP_WIDTH-1:0]      write_level_delay,
	output logic [TAP_WIDTH-1:0]      read_eye_delay,
	output logic [TAP_WIDTH-1:0]      gate_level_delay,
	output logic                      active,
	output logic                      failed
);

	logic [TAP_WIDTH-1:0] seed       [`DPL_MODES];
	logic [TAP_WIDTH-1:0] result     [`DPL_MODES];
	logic [TAP_WIDTH-1:0] next_seed  [`DPL_MODES];
	logic [TAP_WIDTH-1:0] next_result[`DPL_MODES];
	logic [TAP_WIDTH-1:0] delay;
	logic [TAP_WIDTH-1:0] next_delay;
	logic [1:0]           mode;
	logic [1:0]           next_mode;
	logic                 next_active;
	logic                 next_failed;
	logic [TAP_WIDTH-1:0] next_write_level_delay;
	logic [TAP_WIDTH-1:0] next_read_eye_delay;
	logic [TAP_WIDTH-1:0] next_gate_level_delay;

	always_comb begin
		next_seed   = seed;
		next_result = result;
		next_delay  = delay;
		next_mode   = mode;
		next_active = active;
		next_failed = failed;
		// Seeds only change between runs so a search never sees its start move
		// Mode code 11 has no seed slot
		if (seed_load && !active && seed_mode != 2'b11) begin
			next_seed[seed_mode] = seed_value;
		end
		if (run_start) begin
			next_delay  = seed[run_mode];
			next_mode   = run_mode;
			next_active = 1'b1;
			next_failed = 1'b0;
		end else if (active && sample_tick) begin
			if (feedback) begin
				next_active  = 1'b0;
				next_result[mode] = delay;
			end else if (delay == `DPL_TAP_MAX) begin
				// Out of range: keep the last tap, flag the lane
				next_active  = 1'b0;
				next_failed  = 1'b1;
				next_result[mode] = delay;
			end else begin
				next_delay = delay + TAP_WIDTH'(1);
			end
		end
		// Live delay while searching, final result afterwards; taps of 1/256 period
		next_write_level_delay = next_result[DPL_MODE_WRITE];
		next_read_eye_delay    = next_result[DPL_MODE_EYE];
		next_gate_level_delay  = next_result[DPL_MODE_GATE];
		if (next_active) begin
			case (next_mode)
				DPL_MODE_WRITE: next_write_level_delay = next_delay;
				DPL_MODE_EYE:   next_read_eye_delay    = next_delay;
				DPL_MODE_GATE:  next_gate_level_delay  = next_delay;
				default:        next_write_level_delay = next_result[DPL_MODE_WRITE];
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int m = 0; m < `DPL_MODES; m++) begin
				seed[m]   <= `DPL_SEED_RESET;
				result[m] <= `DPL_SEED_RESET;
			end
			delay  <= `DPL_SEED_RESET;
			mode   <= 2'b00;
			write_level_delay <= `DPL_SEED_RESET;
			read_eye_delay    <= `DPL_SEED_RESET;
			gate_level_delay  <= `DPL_SEED_RESET;
			active <= 1'b0;
			failed <= 1'b0;
		end else if (clock_enable) begin
			seed   <= next_seed;
			result <= next_result;
			delay  <= next_delay;
			mode   <= next_mode;
			write_level_delay <= next_write_level_delay;
			read_eye_delay    <= next_read_eye_delay;
			gate_level_delay  <= next_gate_level_delay;
			active <= next_active;
			failed <= next_failed;
		end
	end

endmodule

// ==== dpl_leveling_properties.sv ====
`timescale 1ns/10ps
module dpl_leveling_properties
	import dpl_pkg::*;
#(
	parameter int LANES     = 9,
	parameter int TAP_WIDTH = 8
) (
	input wire logic                       clock,
	input wire logic                       reset,
	input wire logic                       clock_enable,
	input wire logic                       level_start,
	input wire logic [1:0]                 level_mode,
	input wire logic                       clock_output_polarity_flip,
	input wire logic [LANES*TAP_WIDTH-1:0] write_level_delay,
	input wire logic                       level_busy,
	input wire logic                       write_level_done,
	input wire logic                       read_eye_done,
	input wire logic                       gate_level_done,
	input wire logic                       memory_clock
);
	// ==========
	// Run length watch
	logic [11:0] busy_cycles;
	logic [11:0] next_busy_cycles;
	logic [7:0]  first_write;
	assign first_write = write_level_delay[7:0];
	always_comb begin
		next_busy_cycles = level_busy ? busy_cycles + 12'h001 : 12'h000;
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			busy_cycles <= 12'h000;
		end else begin
			busy_cycles <= next_busy_cycles;
		end
	end
	// ==========
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_start;
		!level_busy && level_start && clock_enable && level_mode != 2'h3;
	endsequence
	sequence s_finish;
		level_busy ##1 !level_busy;
	endsequence
	chk_start_busy: assert property (s_start |=> level_busy)
		else $error("start not followed by busy");
	chk_done_on_finish: assert property (s_finish |->
		$rose(write_level_done) || $rose(read_eye_done) || $rose(gate_level_done))
		else $error("run ended without done");
	chk_write_done_clear: assert property (s_start ##0 level_mode == 2'h0 |-> ##[1:2] !write_level_done)
		else $error("write done not cleared");
	chk_clock_toggle: assert property (clock_enable && !$past(reset) &&
		$stable(clock_output_polarity_flip) |=> memory_clock != $past(memory_clock))
		else $error("memory clock did not toggle");
	chk_flip_shift: assert property (clock_enable && !$past(reset) &&
		$changed(clock_output_polarity_flip) |=> memory_clock == $past(memory_clock))
		else $error("polarity flip did not shift clock");
	chk_freeze: assert property (!clock_enable |=> $stable(memory_clock) && $stable(level_busy))
		else $error("outputs moved while frozen");
	chk_write_step: assert property (level_busy && $past(level_busy, 2) |->
		first_write - $past(first_write) <= 8'h01)
		else $error("write delay stepped down or jumped");
	chk_run_bounded: assert property (busy_cycles < 12'h44C)
		else $error("run too long");
endmodule

bind dpl_leveling dpl_leveling_properties #(.LANES(LANES), .TAP_WIDTH(TAP_WIDTH)) u_properties (
	.clock(clock), .reset(reset), .clock_enable(clock_enable), .level_start(level_start),
	.level_mode(level_mode), .clock_output_polarity_flip(clock_output_polarity_flip),
	.write_level_delay(write_level_delay), .level_busy(level_busy), .write_level_done(write_level_done),
	.read_eye_done(read_eye_done), .gate_level_done(gate_level_done), .memory_clock(memory_clock)
);

// ==== dpl_dram_model.sv ====
`timescale 1ns/10ps
module dpl_dram_model (
	input  wire logic [1:0]  level_mode,
	input  wire logic [71:0] write_level_delay,
	input  wire logic [71:0] read_eye_delay,
	input  wire logic [71:0] gate_level_delay,
	input  wire logic [71:0] align_tap,
	output logic [8:0]       lane_feedback
);
	// Each lane aligns only past its own board delay
	logic [71:0] live;
	always_comb begin
		live = level_mode == 2'h0 ? write_level_delay : level_mode == 2'h1 ? read_eye_delay : gate_level_delay;
		for (int g = 0; g < 9; g++) begin
			lane_feedback[g] = live[g*8 +: 8] > align_tap[g*8 +: 8];
		end
	end
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
	logic        clock, reset, clock_enable, seed_load, level_start, flip, busy, memory_clock;
	logic        wr_done, eye_done, gate_done;
	logic [3:0]  seed_lane;
	logic [1:0]  seed_mode, level_mode;
	logic [7:0]  seed_value;
	logic [7:0]  s [9];
	logic [7:0]  t [9];
	logic [8:0]  feedback, failed;
	logic [71:0] wr_d, eye_d, gate_d, align_tap;
	int          fail_count = 0;
	int          cmp_count = 0;
	dpl_leveling dut (.clock(clock), .reset(reset), .clock_enable(clock_enable), .seed_load(seed_load),
		.seed_lane(seed_lane), .seed_mode(seed_mode), .seed_value(seed_value), .level_start(level_start),
		.level_mode(level_mode), .clock_output_polarity_flip(flip), .lane_feedback(feedback),
		.write_level_delay(wr_d), .read_eye_delay(eye_d), .gate_level_delay(gate_d), .level_busy(busy),
		.write_level_done(wr_done), .read_eye_done(eye_done), .gate_level_done(gate_done),
		.lane_failed(failed), .memory_clock(memory_clock));
	dpl_dram_model partner (.level_mode(level_mode), .write_level_delay(wr_d), .read_eye_delay(eye_d),
		.gate_level_delay(gate_d), .align_tap(align_tap), .lane_feedback(feedback));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [71:0] got, input logic [71:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic level_run(input logic [1:0] m, output int n);
		logic [71:0] e;
		logic [8:0]  f;
		for (int g = 0; g < 9; g++) begin
			seed_load <= 1'b1;
			seed_mode <= m;
			seed_lane <= 4'(g);
			seed_value <= s[g];
			align_tap[g*8 +: 8] <= t[g];
			e[g*8 +: 8] = t[g] == 8'hFF ? 8'hFF : t[g] < s[g] ? s[g] : t[g] + 8'h01;
			f[g] = t[g] == 8'hFF;
			@(posedge clock);
		end
		seed_load <= 1'b0;
		level_mode <= m;
		level_start <= 1'b1;
		@(posedge clock);
		level_start <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		check(busy, 1'b1);
		n = 0;
		while (busy === 1'b1 && n < 1200) begin
			@(negedge clock);
			n++;
		end
		check(busy, 1'b0);
		check(m == 2'h0 ? wr_d : m == 2'h1 ? eye_d : gate_d, e);
		check(failed, f);
		check({wr_done, eye_done, gate_done}, 3'(3'h7 << (2'h2 - m)));
		@(posedge clock);
	endtask
	task automatic t_write();
		int n;
		for (int g = 0; g < 9; g++) begin
			s[g] = 8'hC8 - 8'h40 - 8'h80 + 8'(g);
			t[g] = s[g] + 8'(g) - 8'h01;
		end
		level_run(2'h0, n);
		check(n < 60, 1'b1);
		check(eye_d | gate_d, 72'h0);
	endtask
	task automatic t_eye();
		int          n;
		logic [71:0] w;
		w = wr_d;
		for (int g = 0; g < 9; g++) begin
			s[g] = 8'hF0;
			t[g] = g == 8 ? 8'hFF : 8'hF2;
		end
		level_run(2'h1, n);
		check(wr_d, w);
	endtask
	task automatic t_gate();
		int n;
		for (int g = 0; g < 9; g++) begin
			s[g] = 8'h50 + 8'h40 + 8'(g) + 8'h10 - 8'h80;
			t[g] = s[g] + 8'h02;
		end
		level_run(2'h2, n);
	endtask
	task automatic t_clock();
		logic a;
		@(negedge clock);
		a = memory_clock;
		@(posedge clock);
		flip <= 1'b1;
		@(negedge clock);
		check(memory_clock, !a);
		@(negedge clock);
		check(memory_clock, !a);
		@(posedge clock);
		clock_enable <= 1'b0;
		repeat (3) @(negedge clock);
		check(memory_clock, a);
		@(posedge clock);
		clock_enable <= 1'b1;
	endtask
	task automatic t_bad_mode();
		level_mode <= 2'h3;
		level_start <= 1'b1;
		@(posedge clock);
		level_start <= 1'b0;
		@(negedge clock);
		check(busy, 1'b0);
		@(negedge clock);
		check({busy, wr_done, eye_done, gate_done}, 4'h7);
		@(posedge clock);
	endtask
	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		clock_enable = 1'b1;
		seed_load = 1'b0;
		level_start = 1'b0;
		flip = 1'b0;
		seed_lane = 4'h0;
		seed_mode = 2'h0;
		level_mode = 2'h0;
		seed_value = 8'h00;
		align_tap = 72'h0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		check({busy, wr_done, eye_done, gate_done, failed}, 13'h0);
		@(posedge clock);
		t_write();
		t_eye();
		t_gate();
		t_clock();
		t_bad_mode();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		$display("unexpected at %0t: timeout", $time);
		final_report();
	end
endmodule
